//--- rtl/sfa_consts.vh
// Constants for the sensor serial frame block: frame layout, register map, CRC.
// Included by the frame block only; holds definitions only.
`ifndef SFA_CONSTS_VH
`define SFA_CONSTS_VH

// Frame layout
`define SFA_FRAME_BITS      6'h20
// Bit counter stops one past a full frame, so overlong frames never match
`define SFA_CNT_CAP         6'h21
`define SFA_BIT_RW          30
`define SFA_ADDR_HI         29
`define SFA_ADDR_LO         25
`define SFA_DATA_HI         21
`define SFA_DATA_LO         6
`define SFA_CRC_HI          4
`define SFA_CRC_LO          0
`define SFA_COV_HI          30
`define SFA_COV_LO          5

// CRC seed, all ones
`define SFA_CRC_SEED        5'h1f

// Primary register offsets
`define SFA_REG_WR_ADDR     5'h01
`define SFA_REG_WR_DHI      5'h02
`define SFA_REG_WR_DLO      5'h03
`define SFA_REG_WR_CMD      5'h04
`define SFA_REG_RD_ADDR     5'h05
`define SFA_REG_RD_CMD      5'h06
`define SFA_REG_RD_DHI      5'h07
`define SFA_REG_RD_DLO      5'h08
`define SFA_REG_ERROR       5'h0f

// Special previous-address codes in the response
`define SFA_PREV_BADCRC     5'h11
`define SFA_PREV_WRITE      5'h10

// Command/status fields of 0x4 and 0x6
`define SFA_CMD_GO          0
`define SFA_STS_BUSY        1
`define SFA_STS_DONE        2
`define SFA_STS_LOCKED      3

`endif

//--- rtl/sfa_spi_frame.v
// SPI mode 3 frame engine with indirect extended-memory window.
// Assumes SPI pins are asynchronous to clk_in and slow enough (<=clk/8)
// to be sampled; extended memory is a small internal array here.
// Notes on behaviour
// - Mode 3 link, capture rising, launch falling.
// - Frame is exactly 32 clocks under select.
// - Request bit 30 one writes, zero reads.
// - Request bits 29..25 hold register address.
// - Write stores bits 21..6; reads ignore them.
// - Request low five bits are CRC of 30..5.
// - Response bit 31 is always one.
// - Response 30..26 echo previous read address; 0x10 after a write.
// - Response 25..23 is three-bit frame counter.
// - Response bit 22 is error summary, slew too.
// - Response bit 5 is second error summary.
// - Summary holds until reported and cause gone; here it clears only at a later write or bad-CRC frame.
// - Response data is register (angle after a write), CRC over 30..5.
// - CRC x5+x2+1, seeded all ones.
// - CRC over 26 bits, most significant first.
// - Bad CRC frames change no register.
// - Write extended via 0x1, 0x2, 0x3, 0x4.
// - Read extended via 0x5, 0x6, 0x7, 0x8.
// - Device performs indirect access, posts result.
// - Locked extended writes are suppressed.
// - After bad CRC, answer 0x11 and errors.
`timescale 1ns/1ps
`include "sfa_consts.vh"

module sfa_spi_frame #(
  parameter EXT_AW = 6
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_n_in,
  // SPI pins
  input  wire        spi_sclk_in,
  input  wire        spi_cs_n_in,
  input  wire        spi_mosi_in,
  output reg         spi_miso_out,
  output reg         spi_miso_oe_out,
  // Device status
  input  wire [15:0] error_flags_in,
  input  wire [15:0] error_mask_in,
  input  wire        encoder_slew_limited_in,
  input  wire [15:0] angle_in,
  input  wire        eeprom_lock_in,
  // Frame events
  output reg         frame_ok_out,
  output reg         frame_bad_out
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BUSY = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  // CRC step, one bit most significant first
  function [4:0] crc_step;
    input [4:0] c;
    input       b;
    reg         fb;
    begin
      fb = c[4] ^ b;
      crc_step = {c[3], c[2], c[1] ^ fb, c[0], fb};
    end
  endfunction

  // CRC of the 26 covered bits
  function [4:0] crc26;
    input [25:0] d;
    integer      i;
    reg   [4:0]  c;
    begin
      c = `SFA_CRC_SEED;
      for (i = 25; i >= 0; i = i - 1)
        c = crc_step(c, d[i]);
      crc26 = c;
    end
  endfunction

  // Two-stage synchronisers; first stages read only by second stages
  reg [1:0] sclk_sync_reg;
  reg [1:0] cs_sync_reg;
  reg [1:0] mosi_sync_reg;
  reg       sclk_prev_reg;
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sclk_sync_reg <= 2'h3;
      cs_sync_reg   <= 2'h3;
      mosi_sync_reg <= 2'h0;
      sclk_prev_reg <= 1'b1;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[0], spi_sclk_in};
      cs_sync_reg   <= {cs_sync_reg[0], spi_cs_n_in};
      mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi_in};
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end

  wire cs_act   = ~cs_sync_reg[1];
  wire sclk_r   = sclk_sync_reg[1] & ~sclk_prev_reg;
  wire sclk_f   = ~sclk_sync_reg[1] & sclk_prev_reg;
  reg  cs_prev_reg;
  wire cs_rise  = cs_sync_reg[1] & ~cs_prev_reg;

  // Frame state
  reg [5:0]  bit_cnt_reg;
  reg [31:0] rx_reg;
  reg [31:0] tx_reg;
  reg [2:0]  fcnt_reg;
  reg [31:0] resp_reg;      // Last loaded response, resent after a cut frame
  reg        err_latch_reg;
  reg        err_shown_reg;

  // Primary registers
  reg [15:0] wr_addr_reg;
  reg [15:0] wr_dhi_reg;
  reg [15:0] wr_dlo_reg;
  reg [15:0] rd_addr_reg;
  reg [15:0] rd_dhi_reg;
  reg [15:0] rd_dlo_reg;
  reg [3:0]  wr_sts_reg;
  reg [3:0]  rd_sts_reg;
  reg [2:0]  ext_st_reg;
  reg        ext_is_wr_reg;
  reg [31:0] ext_mem [0:(1<<EXT_AW)-1];

  // Error summary from unmasked flags plus slew limiting
  wire err_now = (|(error_flags_in & ~error_mask_in)) | encoder_slew_limited_in;

  // Received request fields
  wire [4:0]  rq_addr = rx_reg[`SFA_ADDR_HI:`SFA_ADDR_LO];
  wire        rq_wr   = rx_reg[`SFA_BIT_RW];
  wire [15:0] rq_data = rx_reg[`SFA_DATA_HI:`SFA_DATA_LO];
  // Bit 31 is never looked at; bits 24..22 and 5 only enter the CRC
  wire        crc_ok  = crc26(rx_reg[`SFA_COV_HI:`SFA_COV_LO]) == rx_reg[`SFA_CRC_HI:`SFA_CRC_LO];

  // Register read mux
  reg [15:0] rd_val;
  always @*
  begin
    case (rq_addr)
      `SFA_REG_WR_ADDR: rd_val = wr_addr_reg;
      `SFA_REG_WR_DHI:  rd_val = wr_dhi_reg;
      `SFA_REG_WR_DLO:  rd_val = wr_dlo_reg;
      `SFA_REG_WR_CMD:  rd_val = {12'h000, wr_sts_reg};
      `SFA_REG_RD_ADDR: rd_val = rd_addr_reg;
      `SFA_REG_RD_CMD:  rd_val = {12'h000, rd_sts_reg};
      `SFA_REG_RD_DHI:  rd_val = rd_dhi_reg;
      `SFA_REG_RD_DLO:  rd_val = rd_dlo_reg;
      `SFA_REG_ERROR:   rd_val = error_flags_in;
      default:          rd_val = 16'h0000;
    endcase
  end

  // Next response word, built when a frame completes
  reg [4:0]  nx_prev;
  reg [15:0] nx_data;
  reg [25:0] nx_cov;
  always @*
  begin
    if (!crc_ok)
    begin
      nx_prev = `SFA_PREV_BADCRC;
      nx_data = error_flags_in;
    end
    else if (rq_wr)
    begin
      nx_prev = `SFA_PREV_WRITE;
      nx_data = angle_in;
    end
    else
    begin
      nx_prev = rq_addr;
      nx_data = rd_val;
    end
    nx_cov = {nx_prev, fcnt_reg + 3'h1, err_latch_reg | err_now, nx_data, err_latch_reg | err_now};
  end

  // Whole response word: start bit, covered bits, CRC
  wire [31:0] nx_word = {1'b1, nx_cov, crc26(nx_cov)};

  wire frame_end = cs_rise & (bit_cnt_reg == `SFA_FRAME_BITS);
  wire do_write  = frame_end & crc_ok & rq_wr;

  // Bit engine: capture on rising, launch on falling
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cs_prev_reg     <= 1'b1;
      bit_cnt_reg     <= 6'h00;
      rx_reg          <= 32'h0000_0000;
      tx_reg          <= 32'h8000_0000;
      spi_miso_out    <= 1'b1;
      spi_miso_oe_out <= 1'b0;
      fcnt_reg        <= 3'h0;
      resp_reg        <= 32'h8000_0000;
      frame_ok_out    <= 1'b0;
      frame_bad_out   <= 1'b0;
    end
    else
    begin
      cs_prev_reg     <= cs_sync_reg[1];
      frame_ok_out    <= 1'b0;
      frame_bad_out   <= 1'b0;
      spi_miso_oe_out <= cs_act;
      if (cs_rise)
      begin
        bit_cnt_reg <= 6'h00;
        if (frame_end)
        begin
          fcnt_reg      <= fcnt_reg + 3'h1;
          frame_ok_out  <= crc_ok;
          frame_bad_out <= ~crc_ok;
          tx_reg        <= nx_word;
          resp_reg      <= nx_word;
        end
        else
        begin
          // A cut frame shifted part of the word out; put it back whole
          frame_bad_out <= 1'b1;
          tx_reg        <= resp_reg;
        end
      end
      else if (cs_act)
      begin
        if (sclk_r && bit_cnt_reg != `SFA_CNT_CAP)
        begin
          rx_reg      <= {rx_reg[30:0], mosi_sync_reg[1]};
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
        end
        if (sclk_f)
        begin
          spi_miso_out <= tx_reg[31];
          tx_reg       <= {tx_reg[30:0], 1'b0};
        end
      end
      else
        spi_miso_out <= tx_reg[31]; // First bit ready before first falling edge
    end
  end

  // Error summary latch: holds until a read reports it, clears at a later write or bad-CRC frame with cause gone; set wins
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      err_latch_reg <= 1'b0;
      err_shown_reg <= 1'b0;
    end
    else if (err_now)
    begin
      err_latch_reg <= 1'b1;
      err_shown_reg <= 1'b0;
    end
    else if (frame_end & crc_ok & ~rq_wr & err_latch_reg)
      err_shown_reg <= 1'b1; // Queued into the next response
    else if (frame_end & err_shown_reg)
    begin
      err_latch_reg <= 1'b0;
      err_shown_reg <= 1'b0;
    end
  end

  // Primary register writes and indirect engine
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_addr_reg   <= 16'h0000;
      wr_dhi_reg    <= 16'h0000;
      wr_dlo_reg    <= 16'h0000;
      rd_addr_reg   <= 16'h0000;
      rd_dhi_reg    <= 16'h0000;
      rd_dlo_reg    <= 16'h0000;
      wr_sts_reg    <= 4'h0;
      rd_sts_reg    <= 4'h0;
      ext_st_reg    <= ST_IDLE;
      ext_is_wr_reg <= 1'b0;
    end
    else
    begin
      if (do_write)
      begin
        case (rq_addr)
          `SFA_REG_WR_ADDR: wr_addr_reg <= rq_data;
          `SFA_REG_WR_DHI:  wr_dhi_reg  <= rq_data;
          `SFA_REG_WR_DLO:  wr_dlo_reg  <= rq_data;
          `SFA_REG_RD_ADDR: rd_addr_reg <= rq_data;
          default:          rd_addr_reg <= rd_addr_reg;
        endcase
      end
      // Commands start only from idle; a go bit while busy is dropped
      case (ext_st_reg)
        ST_IDLE:
        begin
          if (do_write && rq_addr == `SFA_REG_WR_CMD && rq_data[`SFA_CMD_GO])
          begin
            ext_is_wr_reg <= 1'b1;
            wr_sts_reg    <= 4'h0;
            wr_sts_reg[`SFA_STS_BUSY] <= 1'b1;
            ext_st_reg    <= ST_BUSY;
          end
          else if (do_write && rq_addr == `SFA_REG_RD_CMD && rq_data[`SFA_CMD_GO])
          begin
            ext_is_wr_reg <= 1'b0;
            rd_sts_reg    <= 4'h0;
            rd_sts_reg[`SFA_STS_BUSY] <= 1'b1;
            ext_st_reg    <= ST_BUSY;
          end
        end
        ST_BUSY:
        begin
          if (ext_is_wr_reg)
          begin
            if (eeprom_lock_in)
              wr_sts_reg[`SFA_STS_LOCKED] <= 1'b1;
            else
              ext_mem[wr_addr_reg[EXT_AW-1:0]] <= {wr_dhi_reg, wr_dlo_reg};
          end
          else
          begin
            rd_dhi_reg <= ext_mem[rd_addr_reg[EXT_AW-1:0]][31:16];
            rd_dlo_reg <= ext_mem[rd_addr_reg[EXT_AW-1:0]][15:0];
          end
          ext_st_reg <= ST_DONE;
        end
        ST_DONE:
        begin
          if (ext_is_wr_reg)
          begin
            wr_sts_reg[`SFA_STS_BUSY] <= 1'b0;
            wr_sts_reg[`SFA_STS_DONE] <= 1'b1;
          end
          else
          begin
            rd_sts_reg[`SFA_STS_BUSY] <= 1'b0;
            rd_sts_reg[`SFA_STS_DONE] <= 1'b1;
          end
          ext_st_reg <= ST_IDLE;
        end
        default: ext_st_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // sfa_spi_frame

//--- verif/sfa_frame_monitor.sv
// Checker for the serial frame block, bound to the design module.
// Sees only the block's ports; all checks in the clk_in domain.
`timescale 1ns/1ps
module sfa_frame_monitor (
  // Clock, reset and link pins
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe_out,
  // Frame events
  input wire logic frame_ok_out,
  input wire logic frame_bad_out
);
  logic [5:0] cnt_reg;
  logic [5:0] last_reg;
  logic       sck_reg;
  logic       cs_reg;
  // Count link clock rises per frame; keep the count past select rise
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= 6'h00;
      last_reg <= 6'h00;
      sck_reg <= 1'b1;
      cs_reg <= 1'b1;
    end
    else
    begin
      sck_reg <= spi_sclk_in;
      cs_reg <= spi_cs_n_in;
      if (spi_cs_n_in && !cs_reg)
        last_reg <= cnt_reg;
      if (spi_cs_n_in)
        cnt_reg <= 6'h00;
      else if (spi_sclk_in && !sck_reg)
        cnt_reg <= cnt_reg + 6'h01;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_oe_idle: assert property (spi_cs_n_in [*5] |-> !spi_miso_oe_out)
    else $error("miso enabled while idle");
  a_oe_frame: assert property (!spi_cs_n_in [*5] |-> spi_miso_oe_out)
    else $error("miso not enabled in frame");
  a_miso_hold: assert property ((spi_sclk_in && !spi_cs_n_in) [*3] |-> $stable(spi_miso_out))
    else $error("miso moved while clock high");
  a_pulse_excl: assert property (!(frame_ok_out && frame_bad_out))
    else $error("good and bad together");
  a_ok_single: assert property (frame_ok_out |=> !frame_ok_out)
    else $error("good pulse too long");
  a_bad_single: assert property (frame_bad_out |=> !frame_bad_out)
    else $error("bad pulse too long");
  a_pulse_cs: assert property ((frame_ok_out || frame_bad_out) |-> spi_cs_n_in && $past(spi_cs_n_in, 3))
    else $error("frame event inside frame");
  a_ok_count: assert property (frame_ok_out |-> last_reg == 6'h20)
    else $error("good frame without 32 clocks");
  a_short_bad: assert property ($rose(spi_cs_n_in) && cnt_reg != 6'h20 && cnt_reg != 6'h00 |-> ##[1:8] frame_bad_out)
    else $error("short frame not flagged");
  c_good: cover property (frame_ok_out);
  c_bad: cover property (frame_bad_out);
  c_short: cover property ($rose(spi_cs_n_in) && cnt_reg == 6'h14);
endmodule // sfa_frame_monitor

bind sfa_spi_frame sfa_frame_monitor u_mon (.clk_in(clk_in), .rst_n_in(rst_n_in), .spi_sclk_in(spi_sclk_in),
  .spi_cs_n_in(spi_cs_n_in), .spi_miso_out(spi_miso_out), .spi_miso_oe_out(spi_miso_oe_out),
  .frame_ok_out(frame_ok_out), .frame_bad_out(frame_bad_out));

//--- verif/sfa_host_model.sv
// Link controller model: mode 3 frames of 32 bits with CRC.
// Steps align to clk_in; link clock stands high between frames.
`timescale 1ns/1ps
module sfa_host_model (
  input  wire clk_in,
  input  wire spi_miso_in,
  output reg  spi_sclk_out,
  output reg  spi_cs_n_out,
  output reg  spi_mosi_out
);
  // Idle level of the link
  initial
  begin
    spi_sclk_out = 1'b1;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
  end
  // Seeded all ones, 26 bits, top bit first
  function [4:0] crc5(input [25:0] v);
    integer i;
    reg     fb;
    begin
      crc5 = 5'h1f;
      for (i = 25; i >= 0; i = i - 1)
      begin
        fb = crc5[4] ^ v[i];
        crc5 = {crc5[3], crc5[2], crc5[1] ^ fb, crc5[0], fb};
      end
    end
  endfunction
  // One frame of nb clocks; bad flips a CRC bit
  task xfer(input rw, input [4:0] a, input [15:0] d, input [2:0] jk, input bad,
            input [5:0] nb, output [31:0] r);
    reg [31:0] w;
    integer    i;
    begin
      w[31:5] = {1'b0, rw, a, jk, d, jk[0]};
      w[4:0] = crc5(w[30:5]) ^ {4'h0, bad};
      r = 32'h0000_0000;
      @(posedge clk_in);
      #1 spi_cs_n_out = 1'b0;
      #160;
      for (i = 0; i < nb; i = i + 1)
      begin
        spi_sclk_out = 1'b0;
        spi_mosi_out = w[31 - i];
        #160 spi_sclk_out = 1'b1;
        r = {r[30:0], spi_miso_in};
        #160;
      end
      spi_cs_n_out = 1'b1;
      spi_mosi_out = ~spi_mosi_out; // Released line shows no stale bit
      #160;
    end
  endtask
endmodule // sfa_host_model

//--- verif/testbench.sv
// Self-checking bench for the serial frame block.
// Host model drives the link; bench drives status inputs.
`timescale 1ns/1ps
module testbench;
  reg         clk_in = 1'b0;
  reg         rst_n_in = 1'b0;
  reg  [15:0] flags = 16'h0000;
  reg  [15:0] mask = 16'h0000;
  reg  [15:0] angle = 16'h5a3c;
  reg         slew = 1'b0;
  reg         lock = 1'b0;
  wire        sclk, cs_n, mosi, miso, f_ok, f_bad;
  integer     err_count = 0, cmp_count = 0, cycles = 0, e_s = 0, s_nx = 0;
  reg  [4:0]  e_prev = 5'h00;
  reg  [15:0] e_data = 16'h0000, e_mask = 16'h0000;
  reg  [2:0]  last_fc = 3'h0, jk = 3'h0;
  reg         fc_ok = 1'b0;
  integer     n_ok = 0, n_bad = 0;
  always #20 clk_in = ~clk_in;
  // Event pulses last one cycle and may end before the host returns; count them mid-cycle
  always @(negedge clk_in)
  begin
    n_ok = n_ok + f_ok;
    n_bad = n_bad + f_bad;
  end
  sfa_spi_frame uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(), .error_flags_in(flags),
    .error_mask_in(mask), .encoder_slew_limited_in(slew), .angle_in(angle), .eeprom_lock_in(lock),
    .frame_ok_out(f_ok), .frame_bad_out(f_bad));
  sfa_host_model host (.clk_in(clk_in), .spi_miso_in(miso), .spi_sclk_out(sclk), .spi_cs_n_out(cs_n),
    .spi_mosi_out(mosi));
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task conclude;
  begin
    $display("compares=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // Hang guard: about four times the expected run
  always @(posedge clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      err_count = err_count + 1;
      conclude;
    end
  end
  // One frame; judges the response of the previous one and the events
  task op(input rw, input [4:0] a, input [15:0] d, input bad, input [5:0] nb,
          input [4:0] np, input [15:0] nd, input [15:0] nm);
    reg [31:0] r;
    integer    ok0, bad0;
    begin
      jk = jk + 3'h3;
      ok0 = n_ok;
      bad0 = n_bad;
      host.xfer(rw, a, d, jk, bad, nb, r);
      repeat (12) @(posedge clk_in);
      #1;
      chk(n_ok - ok0, nb == 32 && !bad);
      chk(n_bad - bad0, nb != 32 || bad);
      if (nb == 32)
      begin
        if (fc_ok)
        begin
          chk(r[31], 1);
          chk(r[30:26], e_prev);
          chk(r[25:23], last_fc);
          chk(r[21:6] & e_mask, e_data & e_mask);
          chk(r[4:0], host.crc5(r[30:5]));
          if (e_s < 2) chk(r[22], e_s);
          if (e_s < 2) chk(r[5], e_s);
        end
        last_fc = last_fc + 3'h1; // Bench counts complete frames itself
        fc_ok = 1'b1;
        e_prev = np;
        e_data = nd;
        e_mask = nm;
        e_s = s_nx;
      end
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    op(1'b1, a, d, 1'b0, 6'd32, 5'h10, angle, 16'hffff);
  endtask
  task rd(input [4:0] a, input [15:0] e, input [15:0] m);
    op(1'b0, a, 16'hffff, 1'b0, 6'd32, a, e, m);
  endtask
  // Primary writes, reads ignore their data field, indirect access
  task t_window;
  begin
    wr(5'h01, 16'h0003);
    wr(5'h02, 16'hbeef);
    wr(5'h03, 16'h1234);
    rd(5'h01, 16'h0003, 16'hffff);
    rd(5'h01, 16'h0003, 16'hffff);
    wr(5'h04, 16'h0001);
    wr(5'h05, 16'h0003);
    wr(5'h06, 16'h0001);
    rd(5'h07, 16'hbeef, 16'hffff);
    rd(5'h08, 16'h1234, 16'hffff);
    rd(5'h04, 16'h0004, 16'h000c);
    lock = 1'b1;
    wr(5'h02, 16'h0bad);
    wr(5'h04, 16'h0001);
    rd(5'h04, 16'h0008, 16'h0008);
    lock = 1'b0;
    wr(5'h06, 16'h0001);
    rd(5'h07, 16'hbeef, 16'hffff);
    rd(5'h02, 16'h0bad, 16'hffff);
    rd(5'h00, 16'h0000, 16'h0000);
  end
  endtask
  // Bad CRC and short frames change no register
  task t_refuse;
  begin
    op(1'b1, 5'h03, 16'h5555, 1'b1, 6'd32, 5'h11, flags, 16'hffff);
    rd(5'h03, 16'h1234, 16'hffff);
    op(1'b1, 5'h03, 16'h7777, 1'b0, 6'd20, 5'h00, 16'h0000, 16'h0000);
    rd(5'h03, 16'h1234, 16'hffff);
    rd(5'h00, 16'h0000, 16'h0000);
  end
  endtask
  // Error summary: masking, slew, hold until reported
  task t_summary;
  begin
    flags = 16'h0004;
    mask = 16'h0004;
    rd(5'h0f, 16'h0004, 16'hffff);
    mask = 16'h0000;
    e_s = 2;
    s_nx = 1;
    rd(5'h0f, 16'h0004, 16'hffff);
    flags = 16'h0000;
    s_nx = 2;
    rd(5'h00, 16'h0000, 16'h0000);
    rd(5'h00, 16'h0000, 16'h0000);
    s_nx = 0;
    rd(5'h00, 16'h0000, 16'h0000);
    slew = 1'b1;
    e_s = 2;
    s_nx = 1;
    rd(5'h00, 16'h0000, 16'h0000);
    slew = 1'b0;
    s_nx = 2;
    rd(5'h00, 16'h0000, 16'h0000);
    rd(5'h00, 16'h0000, 16'h0000);
    flags = 16'h0004;
    repeat (2) @(posedge clk_in);
    #1 flags = 16'h0000;
    s_nx = 1;
    rd(5'h00, 16'h0000, 16'h0000);
    s_nx = 2;
    rd(5'h00, 16'h0000, 16'h0000);
  end
  endtask
  // Reset for 4 clocks, then the scenarios
  initial
  begin
    repeat (4) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    t_window;
    t_refuse;
    t_summary;
    conclude;
  end
endmodule // testbench
